// ### logic/serial_sram_core.sv
// Purpose: Device side of a serial static memory with one, two or four data lines.
// Assumes: Serial clock well below clk_in; pins pass a two-stage synchroniser.
// Notes:   rst_in stands for power-up; there is no other reset.
//
// How it works
// - Single-line mode samples command, address and data on serial clock rise.
// - Output data changes only after a serial clock fall.
// - Pause input low mid-sequence suspends the transfer, keeping its place.
// - Pause acts at once with clock low, else at next falling edge.
// - While paused the output floats and clock and data are ignored.
// - Pause works in one and two line modes; four-line uses it as data.
// - Each sequence first loads an 8-bit instruction register.
// - First command bit is taken on first clock rise after select.
// - Power-up starts in single-line mode; wide modes need their command.
// - Wide mode stays until power loss or the return command.
// - Everything moves most significant bit first.
// - Opcodes: read 03h, write 02h, mode read 05h, mode write 01h.
// - 38h enters four-line, 3Bh two-line, FFh returns to single-line.
// - A 24-bit address follows; its top 7 bits are ignored.
// - Reads need four dummy clocks in two-line, two in four-line mode.
// - Reads step the address per byte, wrapping 1FFFFh to 00000h.
// - Reads end only when chip select rises.
// - Page writes step within a 32-byte page and wrap inside it.
// - Burst writes step across the array, wrapping 1FFFFh to 00000h.
// - Writes end when chip select rises, or after one byte in word mode; partial bytes are dropped.
// - Mode bits 7:6 select word 00, page 10, burst 01 (default).
// - Mode bit 0 low enables pause (default); high disables it.
// - With chip select high the device idles and its outputs float.
module serial_sram_core import serial_sram_pkg::*; #(
  parameter int ADDR_WIDTH = MEM_ADDR_WIDTH
)(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  input  wire logic [3:0] sio_in,
  output logic      [3:0] sio_out,
  output logic      [3:0] sio_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [4:0] step_of(input io_mode_type m);
    unique case (m)
      IO_SINGLE: step_of = 5'h01;
      IO_DUAL:   step_of = 5'h02;
      default:   step_of = 5'h04;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] d,
                                           input io_mode_type m);
    unique case (m)
      IO_SINGLE: shift_in = {v[22:0], d[0]};
      IO_DUAL:   shift_in = {v[21:0], d[1:0]};
      default:   shift_in = {v[19:0], d};
    endcase
  endfunction

  function automatic logic [3:0] out_bits(input logic [7:0] v, input io_mode_type m);
    unique case (m)
      IO_SINGLE: out_bits = {2'h0, v[7], 1'b0};
      IO_DUAL:   out_bits = {2'h0, v[7:6]};
      default:   out_bits = v[7:4];
    endcase
  endfunction

  function automatic logic [3:0] oe_of(input io_mode_type m);
    unique case (m)
      IO_SINGLE: oe_of = OE_SINGLE;
      IO_DUAL:   oe_of = OE_DUAL;
      default:   oe_of = OE_QUAD;
    endcase
  endfunction

  function automatic logic [ADDR_WIDTH-1:0] next_addr(input logic [ADDR_WIDTH-1:0] a,
                                                      input logic in_page);
    logic [PAGE_BITS-1:0] low;
    low = a[PAGE_BITS-1:0] + {{(PAGE_BITS-1){1'b0}}, 1'b1};
    if (in_page) begin
      next_addr = {a[ADDR_WIDTH-1:PAGE_BITS], low};
    end else begin
      next_addr = a + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture and edges.

  logic [5:0] pins;

  pin_sync #(
    .WIDTH       (6),
    .RESET_VALUE (PIN_RESET)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({cs_n_in, sck_in, sio_in}),
    .sync_out (pins)
  );

  logic                  cs_n_s;
  logic                  sck_s;
  logic [3:0]            sio_s;
  logic                  sck_d;
  logic                  held;
  state_type             state;
  state_type             next_state;
  io_mode_type           io_mode;
  logic [7:0]            mode_reg;
  logic [7:0]            opcode;
  logic [23:0]           sh;
  logic [4:0]            bits;
  logic [ADDR_WIDTH-1:0] addr;
  logic [7:0]            out_sh;
  logic [2:0]            out_cnt;
  logic                  out_on;
  logic [7:0]            rd_data;

  assign cs_n_s = pins[5];
  assign sck_s  = pins[4];
  assign sio_s  = pins[3:0];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pause handling.

  wire       pause_en    = ~mode_reg[PAUSE_DIS_BIT];
  wire       hold_active = ~sio_s[3] & pause_en & (io_mode != IO_QUAD) & ~cs_n_s;
  // With the clock high the pause waits for the next falling edge.
  wire       next_held   = ~cs_n_s & (sck_s ? held : hold_active);
  wire       active      = ~cs_n_s & ~held & (state != ST_IDLE);
  wire       rise        = sck_rise & active;
  wire       fall        = sck_fall & active;

  ////////////////////////////////////////////////////////////////////////////
  // Input phases.

  wire [1:0]  op_mode   = mode_reg[MODE_HI_BIT:MODE_LO_BIT];
  wire        in_page   = (op_mode == OPMODE_PAGE);
  wire [4:0]  step      = step_of(io_mode);
  wire [4:0]  cnt_inc   = (state == ST_DUMMY) ? 5'h01 : step;
  wire [4:0]  next_bits = bits + cnt_inc;
  wire [23:0] next_sh   = shift_in(sh, sio_s, io_mode);
  wire [4:0]  dummy_len = (io_mode == IO_DUAL) ? DUAL_DUMMY : QUAD_DUMMY;
  wire        is_read   = (opcode == OP_READ);

  logic [4:0] phase_len;

  always_comb begin
    unique case (state)
      ST_CMD:                  phase_len = CMD_BITS;
      ST_ADDR:                 phase_len = ADDR_BITS;
      ST_DUMMY:                phase_len = dummy_len;
      ST_WRITE, ST_MODE_WRITE: phase_len = DATA_BITS;
      default:                 phase_len = 5'h00;
    endcase
  end

  wire phase_done = (next_bits == phase_len);
  wire cmd_done   = rise & (state == ST_CMD) & phase_done;
  wire addr_done  = rise & (state == ST_ADDR) & phase_done;
  wire wr_en      = rise & (state == ST_WRITE) & phase_done;
  wire mode_wr    = rise & (state == ST_MODE_WRITE) & phase_done;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_CMD: begin
        unique case (next_sh[7:0])
          OP_READ, OP_WRITE: next_state = ST_ADDR;
          OP_MODE_READ:      next_state = ST_MODE_READ;
          OP_MODE_WRITE:     next_state = ST_MODE_WRITE;
          default:           next_state = ST_DONE;
        endcase
      end
      ST_ADDR: begin
        if (!is_read) begin
          next_state = ST_WRITE;
        end else if (io_mode == IO_SINGLE) begin
          next_state = ST_READ;
        end else begin
          next_state = ST_DUMMY;
        end
      end
      ST_DUMMY:      next_state = ST_READ;
      ST_WRITE:      next_state = (op_mode == OPMODE_WORD) ? ST_DONE : ST_WRITE;
      ST_MODE_WRITE: next_state = ST_DONE;
      default:       next_state = state;
    endcase
  end

  wire [7:0]  cmd_byte     = next_sh[7:0];
  io_mode_type next_io_mode;
  assign next_io_mode = (cmd_byte == OP_ENTER_QUAD)    ? IO_QUAD   :
                        (cmd_byte == OP_ENTER_DUAL)    ? IO_DUAL   :
                        (cmd_byte == OP_RETURN_SINGLE) ? IO_SINGLE : io_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Output phases.

  wire       reading      = (state == ST_READ) | (state == ST_MODE_READ);
  wire [7:0] out_src      = (state == ST_MODE_READ) ? mode_reg : rd_data;
  wire [7:0] out_cur      = (out_cnt == 3'h0) ? out_src : out_sh;
  wire [2:0] next_out_cnt = out_cnt + step[2:0];
  wire       out_done     = fall & (state == ST_READ) & (next_out_cnt == 3'h0);
  wire       next_out_on  = ~cs_n_s & (out_on | (fall & reading));

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state    <= ST_IDLE;
      bits     <= 5'h00;
      held     <= 1'b0;
      io_mode  <= IO_SINGLE;
      mode_reg <= MODE_RESET;
      opcode   <= 8'h00;
      sh       <= 24'h000000;
      addr     <= '0;
      out_sh   <= 8'h00;
      out_cnt  <= 3'h0;
      out_on   <= 1'b0;
    end else begin
      held   <= next_held;
      out_on <= next_out_on;
      if (cs_n_s) begin
        state   <= ST_IDLE;
        bits    <= 5'h00;
        out_cnt <= 3'h0;
      end else if (state == ST_IDLE) begin
        state <= ST_CMD;
        bits  <= 5'h00;
      end else if (rise && phase_len != 5'h00) begin
        sh    <= next_sh;
        bits  <= phase_done ? 5'h00 : next_bits;
        state <= phase_done ? next_state : state;
        if (cmd_done) begin
          opcode  <= cmd_byte;
          io_mode <= next_io_mode;
        end
        if (addr_done) begin
          addr <= next_sh[ADDR_WIDTH-1:0];
        end
        if (wr_en) begin
          addr <= next_addr(addr, in_page);
        end
        if (mode_wr) begin
          mode_reg <= next_sh[7:0];
        end
      end else if (fall && reading) begin
        out_sh  <= out_cur << step;
        out_cnt <= next_out_cnt;
        if (out_done) begin
          addr <= next_addr(addr, 1'b0);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  sram_array #(
    .ADDR_WIDTH (ADDR_WIDTH),
    .DATA_WIDTH (8)
  ) u_array (
    .clk_in      (clk_in),
    .wr_en_in    (wr_en),
    .wr_addr_in  (addr),
    .wr_data_in  (next_sh[7:0]),
    .rd_addr_in  (addr),
    .rd_data_out (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sio_out    <= 4'h0;
      sio_oe_out <= 4'h0;
    end else begin
      if (fall && reading) begin
        sio_out <= out_bits(out_cur, io_mode);
      end
      // Lowering the pause pin floats the lines at once, even mid-bit.
      sio_oe_out <= (next_out_on && !hold_active) ? oe_of(io_mode) : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_single_sample;
    rise && state == ST_CMD && io_mode == IO_SINGLE |=> sh[0] == $past(sio_s[0]);
  endproperty
  a_single_sample: assert property (p_single_sample) else $error("serial input not sampled on rise");

  property p_out_on_fall;
    $changed(sio_out) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output changed without a falling edge");

  property p_held_freeze;
    held && !cs_n_s |=> $stable(sh) && $stable(addr) && $stable(opcode);
  endproperty
  a_held_freeze: assert property (p_held_freeze) else $error("transfer moved while paused");

  property p_hold_enter;
    hold_active && !sck_s |=> held;
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("pause not taken with clock low");

  property p_pause_float;
    hold_active |=> sio_oe_out == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("output driven while paused");

  property p_quad_no_pause;
    io_mode == IO_QUAD && !sio_s[3] |=> !held;
  endproperty
  a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause taken in four-line mode");

  property p_first_cmd;
    state == ST_IDLE && !cs_n_s |=> state == ST_CMD && bits == 5'h00;
  endproperty
  a_first_cmd: assert property (p_first_cmd) else $error("command phase not started on select");

  property p_power_up;
    rst_in |=> io_mode == IO_SINGLE && mode_reg == MODE_RESET;
  endproperty
  a_power_up: assert property (disable iff (1'b0) p_power_up) else $error("wrong state after reset");

  property p_enter_quad;
    cmd_done && cmd_byte == OP_ENTER_QUAD |=> io_mode == IO_QUAD;
  endproperty
  a_enter_quad: assert property (p_enter_quad) else $error("four-line mode not entered");

  property p_addr_load;
    addr_done |=> addr == $past(next_sh[ADDR_WIDTH-1:0]);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded from low bits");

  property p_read_wrap;
    out_done && addr == '1 |=> addr == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read address did not wrap");

  property p_page_wrap;
    wr_en && in_page |=> addr[ADDR_WIDTH-1:PAGE_BITS] == $past(addr[ADDR_WIDTH-1:PAGE_BITS]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page write left its page");

  property p_standby;
    cs_n_s |=> state == ST_IDLE && sio_oe_out == 4'h0;
  endproperty
  a_standby: assert property (p_standby) else $error("not idle with chip deselected");

endmodule

// ### logic/serial_sram_pkg.sv
// Purpose: Shared constants and types of the serial memory command interface.
// Assumes: Pins are sampled by the 125 MHz system clock.
// Notes:   Opcodes, mode register layout and serial phase lengths live here.
package serial_sram_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE         = 8'h02;
  localparam logic [7:0] OP_MODE_READ     = 8'h05;
  localparam logic [7:0] OP_MODE_WRITE    = 8'h01;
  localparam logic [7:0] OP_ENTER_QUAD    = 8'h38;
  localparam logic [7:0] OP_ENTER_DUAL    = 8'h3B;
  localparam logic [7:0] OP_RETURN_SINGLE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] MODE_RESET    = 8'h40;
  localparam int         MODE_HI_BIT   = 7;
  localparam int         MODE_LO_BIT   = 6;
  localparam int         PAUSE_DIS_BIT = 0;
  localparam logic [1:0] OPMODE_WORD   = 2'h0;
  localparam logic [1:0] OPMODE_PAGE   = 2'h2;
  localparam logic [1:0] OPMODE_BURST  = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam logic [4:0] ADDR_BITS  = 5'h18;
  localparam logic [4:0] DATA_BITS  = 5'h08;
  localparam logic [4:0] DUAL_DUMMY = 5'h04;
  localparam logic [4:0] QUAD_DUMMY = 5'h02;
  localparam int         PAGE_BITS  = 5;
  localparam int         MEM_ADDR_WIDTH = 17;

  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;

  // Order of the synchronised pins: chip select, clock, then data 3..0.
  localparam logic [5:0] PIN_RESET = 6'h28;

  typedef enum logic [1:0] {IO_SINGLE, IO_DUAL, IO_QUAD} io_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE,
    ST_MODE_READ, ST_MODE_WRITE, ST_DONE
  } state_type;

endpackage

// ### logic/pin_sync.sv
// Purpose: Two flip-flop synchroniser for the pin inputs.
// Assumes: Pins are asynchronous to clk_in.
// Notes:   Only the second stage leaves this module.
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage    <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule

// ### logic/sram_array.sv
// Purpose: Byte-wide storage array with one write and one read port.
// Assumes: Single clock; read data is registered.
// Notes:   Contents are undefined after power-up.
module sram_array #(
  parameter int ADDR_WIDTH = 17,
  parameter int DATA_WIDTH = 8
)(
  input  wire logic                  clk_in,
  input  wire logic                  wr_en_in,
  input  wire logic [ADDR_WIDTH-1:0] wr_addr_in,
  input  wire logic [DATA_WIDTH-1:0] wr_data_in,
  input  wire logic [ADDR_WIDTH-1:0] rd_addr_in,
  output logic      [DATA_WIDTH-1:0] rd_data_out
);

  logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

// ### sim/sram_host_model.sv
// Purpose: Host model that masters the serial memory pins in one, two or four line modes.
// Assumes: Half a serial clock lasts HALF system clocks; data changes only while the serial clock is low, except in hold_pause.
// Notes:   A released data line shows the inverse of its last value; the bench adds the pull-up on line 3.
module sram_host_model import serial_sram_pkg::*; #(
  parameter int HALF = 8
)(
  input  wire logic       clk_in,
  input  wire logic [3:0] pin_in,
  output logic            cs_n_out,
  output logic            sck_out,
  output logic      [3:0] val_out,
  output logic      [3:0] en_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int lanes = 1;

  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    val_out  = 4'h8;
    en_out   = 4'h8;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One serial clock: lines change in the low phase and are sampled just before the rise.
  task automatic cycle(input logic [3:0] d, input logic [3:0] en, output logic [3:0] q);
    @(posedge clk_in);
    sck_out <= 1'b0;
    val_out <= (d & en) | ((val_out ^ en_out) & ~en);
    en_out  <= en;
    wait_clk(HALF);
    q = pin_in;
    sck_out <= 1'b1;
    wait_clk(HALF - 1);
  endtask

  task automatic start();
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    wait_clk(HALF);
  endtask

  task automatic stop();
    @(posedge clk_in);
    sck_out <= 1'b0;
    wait_clk(HALF);
    cs_n_out <= 1'b1;
    wait_clk(2 * HALF);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    logic [3:0] q;
    logic [7:0] s;
    s = b;
    for (int i = 0; i < 8 / lanes; i++) begin
      if (lanes == 4) cycle(s[7:4], 4'hF, q);
      else if (lanes == 2) cycle({2'b10, s[7:6]}, 4'hB, q);
      else cycle({3'b100, s[7]}, 4'h9, q);
      s = s << lanes;
    end
  endtask

  task automatic recv_byte(output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8 / lanes; i++) begin
      cycle(4'h8, (lanes == 4) ? 4'h0 : 4'h8, q);
      b = (lanes == 4) ? {b[3:0], q} : (lanes == 2) ? {b[5:0], q[1:0]} : {b[6:0], q[1]};
    end
  endtask

  task automatic dummy(input int n);
    logic [3:0] q;
    repeat (n) cycle(4'h8, (lanes == 4) ? 4'h0 : 4'h8, q);
  endtask

  task automatic cmd(input logic [7:0] op);
    send_byte(op);
    if (op == OP_ENTER_QUAD) lanes = 4;
    else if (op == OP_ENTER_DUAL) lanes = 2;
    else if (op == OP_RETURN_SINGLE) lanes = 1;
  endtask

  // Pauses with the clock high, runs two clocks with junk on the data line, resumes with the clock low.
  task automatic hold_pause(input logic [3:0] junk);
    @(posedge clk_in);
    val_out <= junk & 4'h7;
    wait_clk(HALF);
    repeat (2) begin
      sck_out <= 1'b0;
      wait_clk(HALF);
      sck_out <= 1'b1;
      val_out <= ~junk & 4'h7;
      wait_clk(HALF);
    end
    sck_out <= 1'b0;
    wait_clk(HALF);
    val_out[3] <= 1'b1;
    wait_clk(HALF);
  endtask
endmodule

// ### sim/serial_sram_spi_dual_quad_port_tb.sv
// Purpose: Self-checking bench for the serial memory device core.
// Assumes: A narrow array of 256 bytes so that wrap points are reached quickly.
// Notes:   Pin levels are resolved here from the device enables and the host drive.
module serial_sram_spi_dual_quad_port_tb import serial_sram_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = 8;
  logic       clk_in;
  logic       rst_in;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_val;
  logic [3:0] host_en;
  logic [3:0] pin;
  logic [3:0] sio_out;
  logic [3:0] sio_oe;
  int         n_mismatch = 0;
  int         check_count = 0;

  assign pin = (sio_oe & sio_out) | (~sio_oe & host_en & host_val) | (~sio_oe & ~host_en & {1'b1, host_val[2:0]});

  serial_sram_core #(.ADDR_WIDTH(AW)) dut (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .cs_n_in    (cs_n),
    .sck_in     (sck),
    .sio_in     (pin),
    .sio_out    (sio_out),
    .sio_oe_out (sio_oe)
  );

  sram_host_model host (
    .clk_in   (clk_in),
    .pin_in   (pin),
    .cs_n_out (cs_n),
    .sck_out  (sck),
    .val_out  (host_val),
    .en_out   (host_en)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic open_access(input logic [7:0] op, input logic [23:0] a);
    host.start();
    host.cmd(op);
    host.send_byte(a[23:16]);
    host.send_byte(a[15:8]);
    host.send_byte(a[7:0]);
  endtask

  task automatic write_run(input logic [23:0] a, input logic [7:0] d [$]);
    open_access(OP_WRITE, a);
    foreach (d[i]) host.send_byte(d[i]);
    host.stop();
  endtask

  task automatic read_check(input string what, input logic [23:0] a, input logic [7:0] e [$]);
    logic [7:0] b;
    open_access(OP_READ, a);
    host.dummy((host.lanes == 4) ? 2 : (host.lanes == 2) ? 4 : 0);
    foreach (e[i]) begin
      host.recv_byte(b);
      check(what, e[i], b);
    end
    host.stop();
  endtask

  task automatic simple_cmd(input logic [7:0] op, input logic [7:0] arg, input logic with_arg);
    host.start();
    host.cmd(op);
    if (with_arg) host.send_byte(arg);
    host.stop();
  endtask

  task automatic mode_check(input logic [7:0] exp);
    logic [7:0] b;
    host.start();
    host.cmd(OP_MODE_READ);
    host.recv_byte(b);
    check("mode register", exp, b);
    host.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_single_burst();
    write_run(24'hFE00FE, '{8'hA5, 8'h3C, 8'h96, 8'h5A});
    read_check("burst wrap", 24'h0000FE, '{8'hA5, 8'h3C, 8'h96, 8'h5A});
    check("standby enables", 8'h00, {4'h0, sio_oe});
  endtask

  task automatic t_page_word();
    write_run(24'h000050, '{8'h00, 8'h77});
    simple_cmd(OP_MODE_WRITE, 8'h80, 1'b1);
    mode_check(8'h80);
    write_run(24'h00003E, '{8'h11, 8'h22, 8'h33});
    read_check("page wrap", 24'h00003E, '{8'h11, 8'h22});
    read_check("page start", 24'h000020, '{8'h33});
    simple_cmd(OP_MODE_WRITE, 8'h00, 1'b1);
    write_run(24'h000050, '{8'h44, 8'h55});
    read_check("word mode", 24'h000050, '{8'h44, 8'h77});
    simple_cmd(OP_MODE_WRITE, MODE_RESET, 1'b1);
  endtask

  task automatic t_pause();
    logic [7:0] b;
    host.start();
    host.cmd(OP_READ);
    host.send_byte(8'h00);
    host.hold_pause(4'h1);
    host.send_byte(8'h00);
    host.send_byte(8'hFE);
    host.recv_byte(b);
    check("read after pause", 8'hA5, b);
    check("read enables", 8'h02, {4'h0, sio_oe});
    fork
      host.hold_pause(4'h5);
      begin
        repeat (6) @(posedge clk_in);
        check("paused enables", 8'h00, {4'h0, sio_oe});
      end
    join
    host.stop();
  endtask

  // With the pause turned off, a low pause pin must leave the output driven.
  task automatic t_pause_off();
    logic [7:0] b;
    simple_cmd(OP_MODE_WRITE, 8'h41, 1'b1);
    mode_check(8'h41);
    open_access(OP_READ, 24'h0000FE);
    host.recv_byte(b);
    check("read pause off", 8'hA5, b);
    fork
      host.hold_pause(4'h1);
      begin
        repeat (6) @(posedge clk_in);
        check("unpaused enables", 8'h02, {4'h0, sio_oe});
      end
    join
    host.stop();
    simple_cmd(OP_MODE_WRITE, MODE_RESET, 1'b1);
    mode_check(MODE_RESET);
  endtask

  task automatic t_wide(input logic [7:0] enter_op, input logic [23:0] a);
    simple_cmd(enter_op, 8'h00, 1'b0);
    write_run(a, '{8'hC3, 8'h5A, 8'h0F});
    read_check("wide read", a, '{8'hC3, 8'h5A, 8'h0F});
    simple_cmd(OP_RETURN_SINGLE, 8'h00, 1'b0);
    read_check("back to single", a, '{8'hC3, 8'h5A});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_in);
    n_mismatch++;
    final_report();
  end

  initial begin
    rst_in = 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    t_single_burst();
    t_page_word();
    t_pause();
    t_pause_off();
    t_wide(OP_ENTER_DUAL, 24'h000010);
    t_wide(OP_ENTER_QUAD, 24'h0000A0);
    final_report();
  end
endmodule
